// ---- inc/dbps_regs.vh ----
// Register map, field positions and timing constants of the bank power sequencer
`ifndef DBPS_REGS_VH
`define DBPS_REGS_VH

// Clock period in picoseconds (200 MHz)
`define DBPS_CLK_PS 5000

// Interval figures in nanoseconds
`define DBPS_PREDOWN_NS 200
`define DBPS_SETTLE_NS 50
`define DBPS_FIRST_ACCESS_NS 100
`define DBPS_REFRESH_HOLD_NS 100
`define DBPS_READ_HOLD_NS 20

// Standby limit in microseconds before a bank must be refreshed
`define DBPS_STANDBY_US 2000

// Register byte offsets
`define DBPS_ADDR_W 4
`define DBPS_REG_CTRL 4'h0
`define DBPS_REG_STATUS 4'h4

// Control register fields and reset value
`define DBPS_CTRL_OVERLAP 0
`define DBPS_CTRL_REFRESH_EN 1
`define DBPS_CTRL_RESET 2'h2

// Status register fields
`define DBPS_ST_CUR_LSB 0
`define DBPS_ST_TGT_LSB 3
`define DBPS_ST_STATE_LSB 6
`define DBPS_ST_POWER_LSB 9
`define DBPS_ST_REFRESHING 17

// AXI responses
`define DBPS_RESP_OKAY 2'h0
`define DBPS_RESP_DECERR 2'h3

// Bank geometry
`define DBPS_BANKS 8
`define DBPS_SEL_W 3
`define DBPS_CNT_W 8
`define DBPS_STBY_W 20

`endif

// ---- verilog/dbps_sequencer.v ----
// Bank power-down sequencer for a banked dynamic RAM array, with AXI4-Lite control
`timescale 1ns/10ps
`default_nettype none
`include "dbps_regs.vh"

module dbps_sequencer #(
	parameter [`DBPS_STBY_W-1:0] STANDBY_CYCLES = 20'h6_1A80
) (
	input wire aclk,
	input wire aresetn,
	input wire [`DBPS_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`DBPS_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire address_change,
	input wire board_select_n,
	input wire write_pulse,
	input wire access_request,
	input wire bank_select_bit_0,
	input wire bank_select_bit_1,
	input wire bank_select_bit_2,
	output reg [`DBPS_BANKS-1:0] bank_power_enable,
	output reg [`DBPS_BANKS-1:0] array_enable_n,
	output reg [`DBPS_BANKS-1:0] bank_read_write,
	output reg refresh_start,
	output reg [`DBPS_SEL_W-1:0] refresh_bank,
	output wire mem_ready,
	output wire cycle_stretch
);

	// Ceiling division of a time in ns by the clock period
	function [`DBPS_CNT_W-1:0] ns_to_cyc;
		input integer ns;
		integer c;
		begin
			c = (ns * 1000 + `DBPS_CLK_PS - 1) / `DBPS_CLK_PS;
			if (c < 1) begin
				c = 1;
			end
			ns_to_cyc = c[`DBPS_CNT_W-1:0];
		end
	endfunction

	// One-hot decode of a bank number
	function [`DBPS_BANKS-1:0] bank_onehot;
		input [`DBPS_SEL_W-1:0] b;
		begin
			bank_onehot = {{(`DBPS_BANKS-1){1'b0}}, 1'b1} << b;
		end
	endfunction

	// Lowest-numbered bank whose standby timer has expired
	function [`DBPS_SEL_W-1:0] first_set;
		input [`DBPS_BANKS-1:0] v;
		integer i;
		begin
			first_set = {`DBPS_SEL_W{1'b0}};
			for (i = `DBPS_BANKS - 1; i >= 0; i = i - 1) begin
				if (v[i]) begin
					first_set = i[`DBPS_SEL_W-1:0];
				end
			end
		end
	endfunction

	localparam [`DBPS_CNT_W-1:0] PREDOWN_CYC = ns_to_cyc(`DBPS_PREDOWN_NS);
	localparam [`DBPS_CNT_W-1:0] SETTLE_CYC = ns_to_cyc(`DBPS_SETTLE_NS);
	localparam [`DBPS_CNT_W-1:0] FIRST_CYC = ns_to_cyc(`DBPS_FIRST_ACCESS_NS);
	localparam [`DBPS_CNT_W-1:0] REFRESH_CYC = ns_to_cyc(`DBPS_REFRESH_HOLD_NS);
	localparam [`DBPS_CNT_W-1:0] CNT_ONE = 8'h01;
	localparam [`DBPS_STBY_W-1:0] STBY_ONE = 20'h0_0001;

	localparam [2:0] ST_ACTIVE = 3'h0;
	localparam [2:0] ST_PREDOWN = 3'h1;
	localparam [2:0] ST_SETTLE = 3'h2;
	localparam [2:0] ST_FIRST = 3'h3;
	localparam [2:0] ST_REFRESH = 3'h4;

	reg [2:0] state_q;
	reg [`DBPS_CNT_W-1:0] cnt_q;
	reg [`DBPS_SEL_W-1:0] cur_q;
	reg [`DBPS_SEL_W-1:0] tgt_q;
	reg [`DBPS_SEL_W-1:0] ret_q;
	reg refreshing_q;
	reg [1:0] ctrl_q;
	reg [`DBPS_STBY_W-1:0] stby_q [0:`DBPS_BANKS-1];
	reg [`DBPS_BANKS-1:0] expired;
	reg aw_full_q;
	reg w_full_q;
	reg [`DBPS_ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [`DBPS_BANKS-1:0] power_d;
	reg [`DBPS_BANKS-1:0] ce_n_d;
	reg [`DBPS_BANKS-1:0] rw_d;

	wire [`DBPS_SEL_W-1:0] new_bank;
	wire accept;
	wire want_refresh;
	wire cnt_done;
	wire overlap_en;

	assign new_bank = {bank_select_bit_2, bank_select_bit_1, bank_select_bit_0};
	assign overlap_en = ctrl_q[`DBPS_CTRL_OVERLAP];

	// Address change taken only when board selected and no write in flight
	assign accept = (state_q == ST_ACTIVE) & address_change & ~board_select_n
		& ~write_pulse & (new_bank != cur_q);

	// Standby refresh yields to a real address change and never cuts a write
	assign want_refresh = (state_q == ST_ACTIVE) & ctrl_q[`DBPS_CTRL_REFRESH_EN]
		& (|expired) & ~write_pulse & ~accept;

	assign cnt_done = (cnt_q == 8'h00);

	// Accesses only in the active state, after first-access hold and, when overlap is off, after settle
	assign mem_ready = (state_q == ST_ACTIVE);
	assign cycle_stretch = (state_q != ST_ACTIVE);

	// Expired flags of the standby timers
	always @* begin : expire_calc
		integer i;
		i = 0;
		expired = {`DBPS_BANKS{1'b0}};
		for (i = 0; i < `DBPS_BANKS; i = i + 1) begin
			expired[i] = (stby_q[i] >= STANDBY_CYCLES);
		end
	end

	// Standby timers: a powered bank restarts, an idle one counts to the limit
	always @(posedge aclk) begin : stby_timers
		integer i;
		for (i = 0; i < `DBPS_BANKS; i = i + 1) begin
			if (!aresetn || bank_power_enable[i]) begin
				stby_q[i] <= {`DBPS_STBY_W{1'b0}};
			end else if (!expired[i]) begin
				stby_q[i] <= stby_q[i] + STBY_ONE;
			end
		end
	end

	// Sequencing state machine
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_ACTIVE;
			cnt_q <= 8'h00;
			cur_q <= 3'h0;
			tgt_q <= 3'h0;
			ret_q <= 3'h0;
			refreshing_q <= 1'b0;
			refresh_start <= 1'b0;
			refresh_bank <= 3'h0;
		end else begin
			refresh_start <= 1'b0;
			case (state_q)
				ST_ACTIVE: begin
					if (accept) begin
						tgt_q <= new_bank;
						state_q <= ST_PREDOWN;
						cnt_q <= PREDOWN_CYC - CNT_ONE;
					end else if (want_refresh) begin
						tgt_q <= first_set(expired);
						ret_q <= cur_q;
						refreshing_q <= 1'b1;
						state_q <= ST_PREDOWN;
						cnt_q <= PREDOWN_CYC - CNT_ONE;
					end
				end
				ST_PREDOWN: begin
					if (cnt_done) begin
						cur_q <= tgt_q;
						if (overlap_en) begin
							// New bank already powered for the whole interval
							state_q <= refreshing_q ? ST_REFRESH : ST_FIRST;
							cnt_q <= refreshing_q ? REFRESH_CYC - CNT_ONE : FIRST_CYC - CNT_ONE;
							refresh_start <= refreshing_q;
							refresh_bank <= tgt_q;
						end else begin
							state_q <= ST_SETTLE;
							cnt_q <= SETTLE_CYC - CNT_ONE;
						end
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_SETTLE: begin
					if (cnt_done) begin
						if (refreshing_q) begin
							state_q <= ST_REFRESH;
							cnt_q <= REFRESH_CYC - CNT_ONE;
							refresh_start <= 1'b1;
							refresh_bank <= cur_q;
						end else begin
							state_q <= ST_FIRST;
							cnt_q <= FIRST_CYC - CNT_ONE;
						end
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_FIRST: begin
					if (cnt_done) begin
						state_q <= ST_ACTIVE;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_REFRESH: begin
					if (cnt_done) begin
						// Go back to the bank the system had addressed
						tgt_q <= ret_q;
						refreshing_q <= 1'b0;
						state_q <= ST_PREDOWN;
						cnt_q <= PREDOWN_CYC - CNT_ONE;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				default: begin
					state_q <= ST_ACTIVE;
					cnt_q <= 8'h00;
				end
			endcase
		end
	end

	// Bank pin values: current bank powered, target bank too in overlapped pre-down, others read and disabled
	always @* begin
		power_d = bank_onehot(cur_q);
		if (overlap_en && state_q == ST_PREDOWN) begin
			power_d = power_d | bank_onehot(tgt_q);
		end
		ce_n_d = {`DBPS_BANKS{1'b1}};
		rw_d = {`DBPS_BANKS{1'b1}};
		if (state_q == ST_ACTIVE) begin
			ce_n_d = ~(bank_onehot(cur_q) & {`DBPS_BANKS{access_request}});
			rw_d = ~(bank_onehot(cur_q) & {`DBPS_BANKS{write_pulse}});
		end
	end

	// Registered bank pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			bank_power_enable <= 8'h01;
			array_enable_n <= 8'hFF;
			bank_read_write <= 8'hFF;
		end else begin
			bank_power_enable <= power_d;
			array_enable_n <= ce_n_d;
			bank_read_write <= rw_d;
		end
	end

	// AXI write channels: address and data taken in either order
	assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DBPS_RESP_OKAY;
			ctrl_q <= `DBPS_CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_full_q && w_full_q && !s_axi_bvalid) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == `DBPS_REG_CTRL) begin
					s_axi_bresp <= `DBPS_RESP_OKAY;
					if (wstrb_q[0]) begin
						ctrl_q <= wdata_q[1:0];
					end
				end else if (awaddr_q == `DBPS_REG_STATUS) begin
					s_axi_bresp <= `DBPS_RESP_OKAY; // Read-only, write ignored
				end else begin
					s_axi_bresp <= `DBPS_RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel: one answer per address, one cycle later
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DBPS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DBPS_RESP_OKAY;
			if (s_axi_araddr == `DBPS_REG_CTRL) begin
				s_axi_rdata[1:0] <= ctrl_q;
			end else if (s_axi_araddr == `DBPS_REG_STATUS) begin
				s_axi_rdata[`DBPS_ST_CUR_LSB +: 3] <= cur_q;
				s_axi_rdata[`DBPS_ST_TGT_LSB +: 3] <= tgt_q;
				s_axi_rdata[`DBPS_ST_STATE_LSB +: 3] <= state_q;
				s_axi_rdata[`DBPS_ST_POWER_LSB +: 8] <= bank_power_enable;
				s_axi_rdata[`DBPS_ST_REFRESHING] <= refreshing_q;
			end else begin
				s_axi_rresp <= `DBPS_RESP_DECERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ---- tb/dbps_sequencer_chk.sv ----
// Port assertions for the bank power sequencer
`timescale 1ns/10ps
`default_nettype none
module dbps_sequencer_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic address_change,
	input wire logic board_select_n,
	input wire logic write_pulse,
	input wire logic bank_select_bit_0,
	input wire logic bank_select_bit_1,
	input wire logic bank_select_bit_2,
	input wire logic [7:0] bank_power_enable,
	input wire logic [7:0] array_enable_n,
	input wire logic [7:0] bank_read_write,
	input wire logic refresh_start,
	input wire logic mem_ready
);
	logic [7:0] hold_q = 8'h00;
	logic [7:0] low_q = 8'h00;
	logic [7:0] bpe;
	logic acc;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A change that the sequencer must take
	assign bpe = bank_power_enable;
	assign acc = mem_ready && address_change && !board_select_n && !write_pulse
		&& !bpe[{bank_select_bit_2, bank_select_bit_1, bank_select_bit_0}];
	// Cycles with every bank quiet, cycles not ready; both saturate so a long run cannot wrap
	always @(posedge aclk) begin
		hold_q <= (&array_enable_n && &bank_read_write) ? hold_q + {7'h00, ~&hold_q} : 8'h00;
		low_q <= !mem_ready ? low_q + {7'h00, ~&low_q} : 8'h00;
	end
	chk_one_bank: assert property (mem_ready |-> $onehot(bpe))
		else $error("several banks powered");
	chk_down_quiet: assert property ((array_enable_n & bank_read_write | bpe) == 8'hff)
		else $error("unpowered bank active");
	chk_predown_hold: assert property (|($past(bpe) & ~bpe) |-> hold_q >= 8'h26)
		else $error("supply cut too early");
	chk_accept_busy: assert property (acc |=> !mem_ready)
		else $error("change not taken");
	chk_switch_time: assert property (acc |-> ##[36:44] (bpe != $past(bpe)))
		else $error("power not moved");
	chk_settle_hold: assert property (|(bpe & ~$past(bpe)) |-> (&array_enable_n) [*8])
		else $error("enabled while settling");
	chk_ready_late: assert property ($rose(mem_ready) |-> low_q >= 8'h3a)
		else $error("cycle too short");
	chk_refresh_quiet: assert property (refresh_start |-> !mem_ready && &array_enable_n)
		else $error("refresh not quiet");
endmodule
bind dbps_sequencer dbps_sequencer_chk i_chk (.aclk(aclk), .aresetn(aresetn),
	.address_change(address_change), .board_select_n(board_select_n),
	.write_pulse(write_pulse), .bank_select_bit_0(bank_select_bit_0),
	.bank_select_bit_1(bank_select_bit_1), .bank_select_bit_2(bank_select_bit_2),
	.bank_power_enable(bank_power_enable), .array_enable_n(array_enable_n),
	.bank_read_write(bank_read_write), .refresh_start(refresh_start), .mem_ready(mem_ready));
`default_nettype wire

// ---- tb/dbps_bank_model.sv ----
// Switched-supply RAM banks seen from their control pins
`timescale 1ns/10ps
`default_nettype none
module dbps_bank_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] bank_power_enable,
	input wire logic [7:0] array_enable_n,
	input wire logic [7:0] bank_read_write,
	output logic fault_q
);
	logic [7:0] full_q;
	// Supply is full one cycle after switch-on; use of a bank not at full supply is a fault
	always @(posedge aclk) begin
		full_q <= aresetn ? bank_power_enable : 8'h00;
		if (!aresetn)
			fault_q <= 1'h0;
		else if (|(~full_q & ~(array_enable_n & bank_read_write)))
			fault_q <= 1'h1;
	end
endmodule
`default_nettype wire

// ---- tb/dbps_sequencer_bench.sv ----
// Self-checking bench for the bank power sequencer
`timescale 1ns/10ps
`default_nettype none
module dbps_sequencer_bench;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [2:0] prot = 3'h0, nb = 3'h0;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic chg = 1'h0, bsel_n = 1'h0, wp = 1'h0, acc = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, rstart, ready, fault, stretch;
	logic [1:0] bresp, rresp;
	logic [2:0] rbank;
	logic [7:0] bpe, ce_n, rw;
	int err_count = 0;
	int comparisons = 0;
	int n;
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	dbps_sequencer #(.STANDBY_CYCLES(20'h0_00c8)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .address_change(chg), .board_select_n(bsel_n),
		.write_pulse(wp), .access_request(acc), .bank_select_bit_0(nb[0]),
		.bank_select_bit_1(nb[1]), .bank_select_bit_2(nb[2]), .bank_power_enable(bpe),
		.array_enable_n(ce_n), .bank_read_write(rw), .refresh_start(rstart),
		.refresh_bank(rbank), .mem_ready(ready), .cycle_stretch(stretch));
	dbps_bank_model i_banks (.aclk(aclk), .aresetn(aresetn), .bank_power_enable(bpe),
		.array_enable_n(ce_n), .bank_read_write(rw), .fault_q(fault));
	// Compare and count
	task automatic check(input logic [31:0] s, input logic [31:0] e, input string what);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask
	// Register write; each channel released at its own handshake
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta = 1'h0, tw = 1'h0, a1, w1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			a1 = !ta && awready;
			w1 = !tw && wready;
			@(posedge aclk);
			if (a1) awvalid <= 1'h0;
			if (w1) wvalid <= 1'h0;
			ta |= a1;
			tw |= w1;
		end
		do @(negedge aclk); while (!bvalid);
		check(bresp, er, "bresp");
		@(posedge aclk);
		bready <= 1'h0;
	endtask
	// Register read with data and response compared
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'h0;
		do @(negedge aclk); while (!rvalid);
		check(rdata, ed, "rdata");
		check(rresp, er, "rresp");
		@(posedge aclk);
		rready <= 1'h0;
	endtask
	// Wait after each edge for a refresh pulse or for ready
	task automatic await(input logic p);
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while ((p ? rstart : ready) !== 1'h1 && n < 300);
	endtask
	// Offer a bank change for one cycle, then time the stretched cycle
	task automatic bank(input logic [2:0] b, input logic s, input logic w, input int en,
		input logic [7:0] mid, input logic [7:0] fin);
		@(posedge aclk);
		nb <= b;
		bsel_n <= s;
		wp <= w;
		chg <= 1'h1;
		@(posedge aclk);
		chg <= 1'h0;
		bsel_n <= 1'h0;
		wp <= 1'h0;
		repeat (20) @(posedge aclk);
		#1;
		check(bpe, mid, "power mid");
		check(stretch, en > 21, "stretch mid");
		await(1'h0);
		check(n + 20, en, "ready delay");
		check(bpe, fin, "power end");
	endtask
	// Report counts and verdict, then stop
	task automatic conclude();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#100000;
		err_count++;
		conclude();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		acc <= 1'h1;
		#1;
		check(bpe, 8'h01, "reset power");
		check(ce_n & rw, 8'hff, "reset pins");
		axr(4'h0, 32'h0000_0002, 2'h0);
		axw(4'h0, 32'h0000_0000, 2'h0);
		@(posedge aclk);
		wstrb <= 4'h0;
		axw(4'h0, 32'h0000_0003, 2'h0);
		wstrb <= 4'hf;
		axr(4'h0, 32'h0000_0000, 2'h0);
		axw(4'h8, 32'h0000_0003, 2'h3);
		axr(4'hc, 32'h0000_0000, 2'h3);
		bank(3'h2, 1'h1, 1'h0, 21, 8'h01, 8'h01);
		bank(3'h2, 1'h0, 1'h1, 21, 8'h01, 8'h01);
		bank(3'h3, 1'h0, 1'h0, 70, 8'h01, 8'h08);
		repeat (2) @(posedge aclk);
		#1;
		check(ce_n, 8'hf7, "bank enabled");
		axr(4'h4, 32'h0000_101b, 2'h0);
		axw(4'h0, 32'h0000_0001, 2'h0);
		bank(3'h5, 1'h0, 1'h0, 60, 8'h28, 8'h20);
		repeat (250) @(posedge aclk);
		axw(4'h0, 32'h0000_0002, 2'h0);
		await(1'h1);
		check(rstart, 1'h1, "refresh pulse");
		check(rbank, 3'h0, "refresh bank");
		check(bpe, 8'h01, "refresh power");
		await(1'h0);
		check(bpe, 8'h20, "power back");
		axw(4'h0, 32'h0000_0000, 2'h0);
		check(fault, 1'h0, "bank misuse");
		conclude();
	end
endmodule
`default_nettype wire
